// ==== sim/host_irq_model.sv ====
// Host model: watches the active-low interrupt line and counts assertions.
// Assumes it shares the device clock and reset.
`timescale 1ns/1ps
`default_nettype none

module host_irq_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Interrupt line from the device
   input wire logic irq_out_n,
   // Falling edges seen
   output logic [15:0] irq_events
);
   logic last_n_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_n_r <= 1'b1;
         irq_events <= 16'h0000;
      end else begin
         last_n_r <= irq_out_n;
         if (last_n_r && !irq_out_n) begin
            irq_events <= irq_events + 16'h0001;
         end
      end
   end
endmodule : host_irq_model

`default_nettype wire

// ==== sim/load_switch_irq_mask_test.sv ====
// Self-checking bench for the load switch interrupt mask block.
// Assumes the package, the constants header and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lsirq_cfg.svh"

module load_switch_irq_mask_test;
   import lsirq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   evt_t evt = '0;
   evt_t mon;
   logic irq_n;
   logic [15:0] irq_events;
   int err_count = 0;
   int checked = 0;
   int exp_events = 0;
   logic [32:0] expq[$];
   logic [3:0] m;
   logic [3:0] e;

   load_switch_irq_mask uut (.clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
      .evt_in(evt), .monitor_out(mon), .irq_out_n(irq_n));
   host_irq_model host (.clk(clk), .rst_n(rst_n), .irq_out_n(irq_n), .irq_events(irq_events));

   initial forever #10 clk = ~clk;

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // One APB transfer; a read notes its expected {pslverr, prdata}.
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] x);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= d;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      if (!w) expq.push_back(x);
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask : xfer

   // One event round: optional mask write, mask read, event held over a live read,
   // then a clearing status read. Outputs are read at a rising edge, before it updates them.
   task automatic event_round(input logic wr, input logic [3:0] mk, input logic [3:0] ek);
      if (wr) xfer(`LSIRQ_MASK_OFS, 1'b1, {28'h0, mk}, 33'h0);
      xfer(`LSIRQ_MASK_OFS, 1'b0, 32'h0, {29'h0, mk});
      evt <= ek;
      repeat (2) @(posedge clk);
      chk({29'h0, mon}, {29'h0, ek});
      xfer(`LSIRQ_LIVE_OFS, 1'b0, 32'h0, {29'h0, ek});
      chk({32'h0, irq_n}, {32'h0, ~|(ek & ~mk)});
      if (|(ek & ~mk)) exp_events++;
      evt <= '0;
      xfer(`LSIRQ_STAT_OFS, 1'b0, 32'h0, {29'h0, ek});
      @(posedge clk);
      chk({32'h0, irq_n}, 33'h1);
      xfer(`LSIRQ_STAT_OFS, 1'b0, 32'h0, 33'h0);
   endtask : event_round

   always @(posedge clk) begin
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && expq.size() > 0) begin
         chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
      end
   end

   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(42159));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({32'h0, irq_n}, 33'h1);
      xfer(`LSIRQ_MASK_OFS, 1'b0, 32'h0, 33'h0);
      xfer(12'h00C, 1'b0, 32'h0, {1'b1, 32'h0});
      for (int i = 0; i < 24; i++) begin
         m = (i < 4) ? 4'h0 : (i < 8) ? 4'hF : 4'($urandom());
         e = (i < 8) ? 4'(1 << (i % 4)) : 4'($urandom());
         event_round(1'b1, m, e);
      end
      chk({17'h0, irq_events}, 33'(exp_events));
      // Mid-run reset with every mask set: all masks must come back cleared.
      xfer(`LSIRQ_MASK_OFS, 1'b1, 32'h0000_000F, 33'h0);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      exp_events = 0;
      event_round(1'b0, 4'h0, 4'h4);
      chk({17'h0, irq_events}, 33'(exp_events));
      chk(33'(expq.size()), 33'h0);
      tally_and_finish();
   end
endmodule : load_switch_irq_mask_test

`default_nettype wire

// ==== src/irq_flag_bit.sv ====
// One sticky interrupt status flag.
// Assumes set and clr are synchronous to clk; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none

module irq_flag_bit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic set,
   input wire logic clr,
   // State
   output logic flag
);

   logic flag_r;
   logic flag_nxt;

   always_comb begin
      flag_nxt = set | (flag_r & ~clr);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;

   set_wins_a: assert property (@(posedge clk) disable iff (!rst_n) set |=> flag)
      else $error("Event lost while its flag was cleared.");

endmodule : irq_flag_bit

`default_nettype wire

// ==== src/load_switch_irq_mask.sv ====
// Interrupt masking for the current-limit events of three load switches and the fault event of switch 1.
// Assumes APB with 32-bit data; event inputs are levels synchronous to clk.
//
// Notes on behaviour
// - Switch 3 current-limit mask is read/write at bit 2, zero after reset.
// - Switch 2 current-limit mask is read/write at bit 1, zero after reset.
// - Switch 1 current-limit mask is read/write at bit 0, zero after reset.
// - An unmasked current-limit event drives the interrupt output low.
// - A masked current-limit event leaves the interrupt output high until its mask is cleared with its status bit still pending.
// - Masks leave monitoring untouched; they act only on the interrupt path.
// - Switch 1 fault mask is read/write at bit 3, like the other masks.
`timescale 1ns/1ps
`default_nettype none
`include "lsirq_cfg.svh"

module load_switch_irq_mask (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire lsirq_pkg::apb_req_t apb_req,
   output lsirq_pkg::apb_rsp_t apb_rsp,
   // Monitor events and their unmasked copy
   input wire lsirq_pkg::evt_t evt_in,
   output lsirq_pkg::evt_t monitor_out,
   // Interrupt to the host
   output logic irq_out_n
);
   import lsirq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic setup;
   logic access;
   logic hit_mask;
   logic hit_stat;
   logic hit_live;
   logic mapped;

   always_comb begin
      setup = apb_req.psel & ~apb_req.penable;
      access = apb_req.psel & apb_req.penable;
      hit_mask = (apb_req.paddr == `LSIRQ_MASK_OFS);
      hit_stat = (apb_req.paddr == `LSIRQ_STAT_OFS);
      hit_live = (apb_req.paddr == `LSIRQ_LIVE_OFS);
      mapped = hit_mask | hit_stat | hit_live;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Mask register and monitor copy.

   evt_t mask_r;
   evt_t mask_nxt;
   evt_t live_r;
   evt_t live_nxt;

   always_comb begin
      mask_nxt = mask_r;
      if (access && apb_req.pwrite && hit_mask) begin
         mask_nxt = evt_t'(apb_req.pwdata[`LSIRQ_EVT_W-1:0]);
      end
      // The monitored levels pass through whatever the masks hold.
      live_nxt = evt_in;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_r <= evt_t'(`LSIRQ_MASK_RST);
         live_r <= evt_t'(`LSIRQ_STAT_RST);
      end else begin
         mask_r <= mask_nxt;
         live_r <= live_nxt;
      end
   end

   assign monitor_out = live_r;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sticky status: set by any event, masked or not; cleared by reading it.

   logic [`LSIRQ_EVT_W-1:0] stat;
   logic [`LSIRQ_EVT_W-1:0] stat_clr;
   logic [`LSIRQ_DATA_W-1:0] rdata_r;
   logic [`LSIRQ_DATA_W-1:0] rdata_nxt;
   logic stat_rd_r;
   logic stat_rd_nxt;

   // Only the bits captured in the setup cycle are cleared, so an event that lands
   // between capture and completion stays pending.
   always_comb begin
      stat_clr = '0;
      if (access && !apb_req.pwrite && stat_rd_r) begin
         stat_clr = rdata_r[`LSIRQ_EVT_W-1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `LSIRQ_EVT_W; gi++) begin : g_flag
         irq_flag_bit u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .set(evt_in[gi]),
            .clr(stat_clr[gi]),
            .flag(stat[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read data is captured in the setup cycle, so pready can stand high.

   always_comb begin
      rdata_nxt = rdata_r;
      stat_rd_nxt = stat_rd_r;
      if (setup) begin
         stat_rd_nxt = ~apb_req.pwrite & hit_stat;
         if (apb_req.pwrite) begin
            rdata_nxt = `LSIRQ_RDATA_RST;
         end else if (hit_mask) begin
            rdata_nxt = {`LSIRQ_UPPER_ZERO, mask_r};
         end else if (hit_stat) begin
            rdata_nxt = {`LSIRQ_UPPER_ZERO, stat};
         end else if (hit_live) begin
            rdata_nxt = {`LSIRQ_UPPER_ZERO, live_r};
         end else begin
            rdata_nxt = `LSIRQ_RDATA_RST;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= `LSIRQ_RDATA_RST;
         stat_rd_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         stat_rd_r <= stat_rd_nxt;
      end
   end

   always_comb begin
      apb_rsp.prdata = rdata_r;
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = access & ~mapped;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Interrupt output: low while any unmasked status bit is pending.

   logic irq_n_r;
   logic irq_n_nxt;
   logic [`LSIRQ_EVT_W-1:0] pend;

   always_comb begin
      pend = stat & ~mask_r;
      irq_n_nxt = ~(|pend);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_n_r <= `LSIRQ_IRQ_IDLE;
      end else begin
         irq_n_r <= irq_n_nxt;
      end
   end

   assign irq_out_n = irq_n_r;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   mask3_reset_a: assert property (@(posedge clk) !rst_n |=> !mask_r.ilim3)
      else $error("Switch 3 limit mask not zero after reset.");

   mask2_reset_a: assert property (@(posedge clk) !rst_n |=> !mask_r.ilim2)
      else $error("Switch 2 limit mask not zero after reset.");

   mask1_reset_a: assert property (@(posedge clk) !rst_n |=> !mask_r.ilim1)
      else $error("Switch 1 limit mask not zero after reset.");

   mask1_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_mask) |=>
      (mask_r.ilim1 == $past(apb_req.pwdata[`LSIRQ_BIT_ILIM1])))
      else $error("Switch 1 limit mask did not take written value.");

   mask3_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_mask) |=>
      (mask_r.ilim3 == $past(apb_req.pwdata[`LSIRQ_BIT_ILIM3])))
      else $error("Switch 3 limit mask did not take written value.");

   mask2_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_mask) |=>
      (mask_r.ilim2 == $past(apb_req.pwdata[`LSIRQ_BIT_ILIM2])))
      else $error("Switch 2 limit mask did not take written value.");

   irq_assert_a: assert property (@(posedge clk) disable iff (!rst_n)
      (evt_in.ilim1 && !mask_r.ilim1 && !mask_nxt.ilim1) |=> ##1 !irq_out_n)
      else $error("Unmasked event did not pull interrupt low.");

   masked_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      ((stat & ~mask_r) == '0) |=> irq_out_n)
      else $error("Interrupt low with only masked events pending.");

   monitor_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 (monitor_out == $past(evt_in)))
      else $error("Monitor copy disturbed.");

   fault_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access && apb_req.pwrite && hit_mask) |=>
      (mask_r.fault1 == $past(apb_req.pwdata[`LSIRQ_BIT_FAULT1])))
      else $error("Fault mask did not take written value.");

   fault_reset_a: assert property (@(posedge clk) !rst_n |=> !mask_r.fault1)
      else $error("Fault mask not zero after reset.");

   // Masked or not, every event must still land in its status bit.
   status_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (evt_in != '0) |=> ((stat & $past(evt_in)) == $past(evt_in)))
      else $error("Event did not reach its status bit.");

   irq_release_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!irq_out_n && ((stat & ~mask_r) == '0)) |=> irq_out_n)
      else $error("Interrupt not released with nothing pending.");

endmodule : load_switch_irq_mask

`default_nettype wire

// ==== src/lsirq_cfg.svh ====
// Constants for the load switch interrupt mask block: offsets, reset values, bit positions.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef LSIRQ_CFG_SVH
`define LSIRQ_CFG_SVH

`define LSIRQ_ADDR_W 12
`define LSIRQ_DATA_W 32
`define LSIRQ_EVT_W 4

`define LSIRQ_MASK_OFS 12'h000
`define LSIRQ_STAT_OFS 12'h004
`define LSIRQ_LIVE_OFS 12'h008

`define LSIRQ_MASK_RST 4'h0
`define LSIRQ_STAT_RST 4'h0
`define LSIRQ_RDATA_RST 32'h0000_0000
`define LSIRQ_UPPER_ZERO 28'h000_0000
`define LSIRQ_IRQ_IDLE 1'b1

`define LSIRQ_BIT_ILIM1 0
`define LSIRQ_BIT_ILIM2 1
`define LSIRQ_BIT_ILIM3 2
`define LSIRQ_BIT_FAULT1 3

`endif

// ==== src/lsirq_pkg.sv ====
// Types shared by the load switch interrupt mask block.
// Assumes lsirq_cfg.svh is on the include path.
`include "lsirq_cfg.svh"

package lsirq_pkg;

   // Event bundle, laid out exactly as the mask and status register bits.
   typedef struct packed {
      logic fault1;
      logic ilim3;
      logic ilim2;
      logic ilim1;
   } evt_t;

   typedef struct packed {
      logic [`LSIRQ_ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [`LSIRQ_DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [`LSIRQ_DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage : lsirq_pkg
